// ---- rtl/tcrs_pkg.sv ----
// Constants shared by the touch controller reset/start-up sequencer ends.
// Assumes a single 125 MHz system clock and synchronous pin inputs.
// Summary of operation
// R1: Device boots itself from internal power-on reset.
// R2: Host holds reset low while supplies ramp.
// R3: Host reset pulse lasts at least 90 ns.
// R4: Ready 135 to 450 ms after release.
// R5: No init or talk while supply absent; the code lets self test run on and finish into ready without supplies.
// R6: Late analog supply: host sends reset command.
// R7: Reset command: ready within 165-480 ms.
// R8: Reset flag set after every reset cycle.
// R9: Assert both pending lines when reset completes; the code drives the serial line only when configured.
// R10: Pending lines float about 100 ms at start.
// R11: Run self tests at power-on if enabled.
// R12: Late io supply: host leaves lines undriven.
// R13: Pulled-up start: drive pending low when ready.
// R14: Host keeps a connection to reset line.
// R15: Host resets only through reset line.
// R16: Host waits for pending or timeout first.
// R17: Device ignores bus requests before ready.
package tcrs_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned RST_MIN_NS = 90;
   localparam int unsigned RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HW_READY_MIN_MS = 135;
   localparam int unsigned HW_READY_MAX_MS = 450;
   localparam int unsigned SW_READY_MIN_MS = 165;
   localparam int unsigned SW_READY_MAX_MS = 480;
   localparam int unsigned FLOAT_MS = 100;
   localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
   localparam int unsigned HW_READY_CYC = HW_READY_MIN_MS * CYC_PER_MS;
   localparam int unsigned HW_READY_MAX_CYC = HW_READY_MAX_MS * CYC_PER_MS;
   localparam int unsigned SW_READY_CYC = SW_READY_MIN_MS * CYC_PER_MS;
   localparam int unsigned SW_READY_MAX_CYC = SW_READY_MAX_MS * CYC_PER_MS;
   localparam int unsigned FLOAT_CYC = FLOAT_MS * CYC_PER_MS;
   localparam int unsigned SELFTEST_CYC = 1000;
   localparam int CNT_W = 32;
   typedef enum logic [2:0]
   {
      TCRS_OFF = 3'b000,
      TCRS_FLOAT = 3'b001,
      TCRS_INIT = 3'b011,
      TCRS_TEST = 3'b010,
      TCRS_READY = 3'b110
   } tcrs_dev_e;
   typedef enum logic [1:0]
   {
      TCRS_H_PULSE = 2'b00,
      TCRS_H_WAIT = 2'b01,
      TCRS_H_UP = 2'b11
   } tcrs_host_e;
endpackage

// ---- rtl/tcrs_if.sv ----
// Pins between the host and the touch controller reset sequencer.
// Assumes the bench resolves the open-drain wires from the enables.
`timescale 1ns/1ps
interface tcrs_if;
   logic reset_n_o;
   logic reset_n_oe;
   logic reset_n_i;
   logic twowire_o;
   logic twowire_oe;
   logic twowire_i;
   logic serial_o;
   logic serial_oe;
   logic serial_i;
   logic bus_req;
   logic bus_ack;
   logic sw_reset_cmd;
   modport dev
   (
      input reset_n_i, twowire_i, serial_i, bus_req, sw_reset_cmd,
      output twowire_o, twowire_oe, serial_o, serial_oe, bus_ack
   );
   modport host
   (
      input twowire_i, serial_i, bus_ack,
      output reset_n_o, reset_n_oe, bus_req, sw_reset_cmd
   );
endinterface

// ---- rtl/tcrs_device.sv ----
// Device end: power-on/reset sequencer driving the message-pending lines.
// Assumes supplies-good inputs are synchronous and host keeps its rules.
`timescale 1ns/1ps
module tcrs_device
   import tcrs_pkg::*;
#(
   parameter int unsigned HW_READY = HW_READY_CYC,
   parameter int unsigned SW_READY = SW_READY_CYC,
   parameter int unsigned FLOAT_TIME = FLOAT_CYC,
   parameter int unsigned TEST_TIME = SELFTEST_CYC
)
(
   input wire logic i_sys_clk,      // System clock
   input wire logic i_reset_n,      // Internal power-on reset
   input wire logic i_supplies_ok,  // All supplies nominal
   input wire logic i_selftest_en,  // Self test at power-on
   input wire logic i_serial_used,  // Serial pending line configured
   input wire logic i_flag_clear,   // Host read the reset message
   output logic o_ready,            // Initialization complete
   output logic o_reset_flag,       // Reset message flag
   output logic o_selftest_busy,    // Self tests running
   tcrs_if.dev pins                 // Link pins
);
   // ****************************************
   // Sequencer state
   // ****************************************

   // Sequencer registers and phase events
   tcrs_dev_e state_ff;
   tcrs_dev_e nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] wait_ff;
   logic power_on_ff;
   logic restart;
   logic done;
   logic phase_change;
   logic count_en;
   logic enter_ready;
   logic [1:0] line_used;
   logic [1:0] line_oe;

   // ****************************************
   // Restart and phase events
   // ****************************************

   // Reset pin low or a reset command restarts the sequence
   assign restart = !pins.reset_n_i || pins.sw_reset_cmd;

   // Initialization ends when the chosen ready delay is counted out
   assign done = (cnt_ff >= wait_ff);

   // Any state change restarts the phase counter
   assign phase_change = (nxt_state != state_ff);

   // Counting stalls while supplies are absent, except in self test
   assign count_en = (state_ff == TCRS_TEST) || (i_supplies_ok && state_ff != TCRS_READY);  // R5

   // Last step into ready, the moment the reset cycle completes
   assign enter_ready = (state_ff != TCRS_READY) && (nxt_state == TCRS_READY);

   // ****************************************
   // Next state
   // ****************************************

   // Supplies gate every step except leaving self test; a restart overrides all
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         TCRS_OFF:
         begin
            if (i_supplies_ok)
               nxt_state = TCRS_FLOAT;  // R1 R5
         end
         TCRS_FLOAT:
         begin
            if (cnt_ff >= CNT_W'(FLOAT_TIME))
               nxt_state = TCRS_INIT;  // R10
         end
         TCRS_INIT:
         begin
            if (!i_supplies_ok)
               nxt_state = TCRS_INIT;  // R5
            else if (done && power_on_ff && i_selftest_en)
               nxt_state = TCRS_TEST;  // R11
            else if (done)
               nxt_state = TCRS_READY;  // R4 R7
         end
         TCRS_TEST:
         begin
            if (cnt_ff >= CNT_W'(TEST_TIME))
               nxt_state = TCRS_READY;  // R11
         end
         TCRS_READY:
         begin
            nxt_state = TCRS_READY;
         end
         default:
         begin
            nxt_state = TCRS_OFF;
         end
      endcase

      // Restart overrides every step
      if (restart)
         nxt_state = TCRS_OFF;
   end

   // ****************************************
   // State and phase counter
   // ****************************************

   // State register
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         state_ff <= TCRS_OFF;
      else
         state_ff <= nxt_state;
   end

   // Phase counter, restarts on each state change
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         cnt_ff <= '0;
      else if (phase_change)
         cnt_ff <= '0;
      else if (count_en)
         cnt_ff <= cnt_ff + 1'b1;  // R5
   end

   // ****************************************
   // Ready delay and power-on marker
   // ****************************************

   // Ready delay chosen by cause of reset
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         wait_ff <= CNT_W'(HW_READY);
      else if (pins.sw_reset_cmd)
         wait_ff <= CNT_W'(SW_READY);  // R7
      else if (!pins.reset_n_i)
         wait_ff <= CNT_W'(HW_READY);  // R4 R13
   end

   // Power-on marker for self tests; cleared once ready
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         power_on_ff <= 1'b1;
      else if (state_ff == TCRS_READY)
         power_on_ff <= 1'b0;  // R11
   end

   // ****************************************
   // Reset flag
   // ****************************************

   // Set on completion wins over a host clear in the same cycle
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_reset_flag <= 1'b0;
      else if (enter_ready)
         o_reset_flag <= 1'b1;  // R8
      else if (i_flag_clear)
         o_reset_flag <= 1'b0;
   end

   // ****************************************
   // Status outputs
   // ****************************************

   // Status follows the sequencer state
   assign o_ready = (state_ff == TCRS_READY);
   assign o_selftest_busy = (state_ff == TCRS_TEST);  // R11

   // ****************************************
   // Message-pending lines
   // ****************************************

   // Two-wire line always in use, serial line only when configured
   assign line_used = {i_serial_used, 1'b1};

   // One open-drain enable per line, on while a message waits
   for (genvar g = 0; g < $bits(line_oe); g++)
   begin : g_line
      assign line_oe[g] = o_ready && o_reset_flag && line_used[g];  // R9 R10 R13
   end

   // Lines are only ever pulled low, never driven high
   always_comb
   begin
      pins.twowire_o = 1'b0;
      pins.serial_o = 1'b0;
      pins.twowire_oe = line_oe[0];  // R9 R13
      pins.serial_oe = line_oe[1];  // R9
   end

   // ****************************************
   // Bus gate
   // ****************************************

   // Host requests are answered only once ready
   assign pins.bus_ack = o_ready && pins.bus_req;  // R17
endmodule

// ---- rtl/tcrs_host.sv ----
// Host end: drives reset and waits for readiness before bus traffic.
// Assumes pull-ups on all lines; the bench resolves wire levels.
`timescale 1ns/1ps
module tcrs_host
   import tcrs_pkg::*;
#(
   parameter int unsigned MAX_WAIT = HW_READY_MAX_CYC
)
(
   input wire logic i_sys_clk,     // System clock
   input wire logic i_reset_n,     // Host reset
   input wire logic i_do_reset,    // Request hardware reset pulse
   input wire logic i_do_cmd,      // Request reset command
   input wire logic i_req,         // User bus request
   output logic o_link_up,         // Device may be addressed
   output logic o_ack,             // Bus request answered
   tcrs_if.host pins               // Link pins
);
   // ****************************************
   // Host sequence
   // ****************************************
   tcrs_host_e state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic cmd_ff;
   logic pending;

   assign pending = !pins.twowire_i || !pins.serial_i;

   // Reset pulse, then wait for pending line or timeout
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_ff <= TCRS_H_PULSE;  // R2
         cnt_ff <= '0;
      end
      else if (i_do_reset)
      begin
         state_ff <= TCRS_H_PULSE;  // R14 R15
         cnt_ff <= '0;
      end
      else if (i_do_cmd && state_ff == TCRS_H_UP)
      begin
         state_ff <= TCRS_H_WAIT;  // R6
         cnt_ff <= '0;
      end
      else
      begin
         unique case (state_ff)
            TCRS_H_PULSE:
               if (cnt_ff >= CNT_W'(RST_MIN_CYC - 1))
               begin
                  state_ff <= TCRS_H_WAIT;  // R3
                  cnt_ff <= '0;
               end
               else
                  cnt_ff <= cnt_ff + 1'b1;
            TCRS_H_WAIT:
               if ((pending && cnt_ff >= CNT_W'(FLOAT_CYC)) || cnt_ff >= CNT_W'(MAX_WAIT))
                  state_ff <= TCRS_H_UP;  // R16
               else
                  cnt_ff <= cnt_ff + 1'b1;
            TCRS_H_UP: state_ff <= TCRS_H_UP;
            default: state_ff <= TCRS_H_PULSE;
         endcase
      end
   end

   // One-cycle reset command pulse
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         cmd_ff <= 1'b0;
      else
         cmd_ff <= i_do_cmd && state_ff == TCRS_H_UP;
   end

   // Pins: reset low only in pulse, pending lines never driven
   always_comb
   begin
      pins.reset_n_o = 1'b0;
      pins.reset_n_oe = (state_ff == TCRS_H_PULSE);  // R12
      pins.sw_reset_cmd = cmd_ff;
      o_link_up = (state_ff == TCRS_H_UP);
      pins.bus_req = o_link_up && i_req;  // R16
      o_ack = pins.bus_ack;
   end
endmodule

// ---- tb/tcrs_properties.sv ----
// Timing checks on the link pins between host and device ends.
// Assumes one clock, async active-low reset, small device timings.
`timescale 1ns/1ps
module tcrs_properties
(
   input wire logic i_sys_clk,    // Clock
   input wire logic i_reset_n,    // Reset
   input wire logic reset_n_i,    // Reset wire
   input wire logic twowire_o,    // Pending data
   input wire logic twowire_oe,   // Pending drive
   input wire logic serial_oe,    // Serial drive
   input wire logic bus_req,      // Bus request
   input wire logic bus_ack,      // Bus answer
   input wire logic sw_reset_cmd  // Reset command
);
   localparam int RDY_MAX = 320;
   logic [7:0] low_cnt;
   logic [15:0] since_cnt;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // Low time of the reset wire
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         low_cnt <= 8'h00;
      else if (reset_n_i)
         low_cnt <= 8'h00;
      else if (low_cnt != 8'hFF)
         low_cnt <= low_cnt + 8'h01;
   end
   // Cycles since the last restart
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         since_cnt <= 16'h0000;
      else if (!reset_n_i || sw_reset_cmd)
         since_cnt <= 16'h0000;
      else if (since_cnt != 16'hFFFF)
         since_cnt <= since_cnt + 16'h0001;
   end
   a_pulse_long_enough: assert property ($rose(reset_n_i) |-> low_cnt >= 8'h0C)
      else $error("reset pulse too short");
   a_float_after_release: assert property ($rose(reset_n_i) |-> (!twowire_oe && !serial_oe) [*8])
      else $error("pending line driven after reset");
   a_float_after_cmd: assert property (sw_reset_cmd |=> (!twowire_oe && !serial_oe) [*8])
      else $error("pending line driven after command");
   a_ack_needs_req: assert property (bus_ack |-> bus_req)
      else $error("answer without request");
   a_no_ack_restart: assert property ($rose(reset_n_i) |-> !bus_ack [*8])
      else $error("answer during start-up");
   a_pending_drives_low: assert property (twowire_oe |-> !twowire_o)
      else $error("pending line driven high");
   a_serial_with_twowire: assert property (serial_oe |-> twowire_oe)
      else $error("serial pending without two-wire pending");
   a_ready_not_early: assert property ($rose(twowire_oe) |-> since_cnt >= 16'h00FA)
      else $error("ready too early");
   a_ready_in_time: assert property ($rose(reset_n_i) |-> ##[1:RDY_MAX] $rose(twowire_oe))
      else $error("ready too late");
   // Main scenarios reached
   cover property ($rose(twowire_oe));
   cover property (sw_reset_cmd);
   cover property (bus_ack);
endmodule

// ---- tb/tcrs_tb.sv ----
// Bench joining host and device ends over the pin interface.
// Assumes small device timings; pull-ups resolved here.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s exp %0h got %0h", nm, e, g); end end
module tcrs_tb;
   localparam int FT = 50;
   localparam int HR = 200;
   localparam int SR = 250;
   logic i_sys_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic sup = 1'b1, ste = 1'b1, ser = 1'b1, fclr = 1'b0, dor = 1'b0, doc = 1'b0, req = 1'b1;
   logic rdy, flg, stb, lnk, ack;
   int n_errors = 0;
   int check_count = 0;
   int n, early, seen;
   tcrs_if lk ();
   // Pull-ups on each open-drain wire
   assign lk.reset_n_i = !(lk.reset_n_oe && !lk.reset_n_o);
   assign lk.twowire_i = !(lk.twowire_oe && !lk.twowire_o);
   assign lk.serial_i = !(lk.serial_oe && !lk.serial_o);
   tcrs_device #(.HW_READY(HR), .SW_READY(SR), .FLOAT_TIME(FT), .TEST_TIME(20)) tcrs_device_i (
      .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_supplies_ok(sup), .i_selftest_en(ste),
      .i_serial_used(ser), .i_flag_clear(fclr), .o_ready(rdy), .o_reset_flag(flg),
      .o_selftest_busy(stb), .pins(lk.dev));
   tcrs_host #(.MAX_WAIT(400)) tcrs_host_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
      .i_do_reset(dor), .i_do_cmd(doc), .i_req(req), .o_link_up(lnk), .o_ack(ack), .pins(lk.host));
   tcrs_properties tcrs_properties_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
      .reset_n_i(lk.reset_n_i), .twowire_o(lk.twowire_o), .twowire_oe(lk.twowire_oe),
      .serial_oe(lk.serial_oe), .bus_req(lk.bus_req), .bus_ack(lk.bus_ack), .sw_reset_cmd(lk.sw_reset_cmd));
   // Clock
   initial
   begin
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   // Verdict and end of run
   task automatic end_sim();
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait for ready or link to reach v
   task automatic wt(input logic v, input bit sel, input int m);
      int k;
      k = 0;
      while ((sel ? lnk : rdy) !== v)
      begin
         @(posedge i_sys_clk);
         #1;
         n++;
         k++;
         if (ack === 1'b1 && rdy !== 1'b1) early++;
         if (stb === 1'b1) seen++;
         if (k > m)
         begin
            n_errors++;
            end_sim();
         end
      end
   endtask
   // One-cycle pulse: 0 flag clear, 1 pin reset, 2 reset command
   task automatic pls(input int sel);
      @(posedge i_sys_clk);
      #1;
      fclr = (sel == 0);
      dor = (sel == 1);
      doc = (sel == 2);
      @(posedge i_sys_clk);
      #1;
      fclr = 1'b0;
      dor = 1'b0;
      doc = 1'b0;
   endtask
   // Power-on start with request held early
   task automatic t_power();
      n = 0;
      early = 0;
      seen = 0;
      `CHK("float", 1'b1, lk.twowire_i)
      wt(1'b1, 1'b0, 600);
      `CHK("hw delay", 1'b1, n >= FT + HR)
      `CHK("early ack", 0, early)
      `CHK("self test", 1'b1, seen > 0)
      `CHK("flag", 1'b1, flg)
      `CHK("twowire low", 1'b0, lk.twowire_i)
      `CHK("serial low", 1'b0, lk.serial_i)
      wt(1'b1, 1'b1, 600);
      `CHK("ack", 1'b1, ack)
   endtask
   // Clear message, then pin reset with serial line unused
   task automatic t_hw();
      pls(0);
      `CHK("released", 1'b1, lk.twowire_i)
      ser = 1'b0;
      n = 0;
      pls(1);
      wt(1'b0, 1'b0, 30);
      wt(1'b1, 1'b0, 600);
      `CHK("hw delay", 1'b1, n >= FT + HR)
      `CHK("flag", 1'b1, flg)
      `CHK("serial idle", 1'b1, lk.serial_i)
      wt(1'b1, 1'b1, 600);
   endtask
   // Reset command with supplies lost for 100 cycles
   task automatic t_sw();
      ser = 1'b1;
      pls(0);
      n = 0;
      seen = 0;
      pls(2);
      wt(1'b0, 1'b0, 30);
      sup = 1'b0;
      repeat (100) @(posedge i_sys_clk);
      #1;
      `CHK("held off", 1'b0, rdy)
      sup = 1'b1;
      wt(1'b1, 1'b0, 1000);
      `CHK("sw delay", 1'b1, n >= FT + SR)
      `CHK("flag", 1'b1, flg)
      `CHK("serial low", 1'b0, lk.serial_i)
      `CHK("no test", 0, seen)
   endtask
   // Main sequence
   initial
   begin
      repeat (8) @(posedge i_sys_clk);
      #1;
      i_reset_n = 1'b1;
      t_power();
      t_hw();
      t_sw();
      end_sim();
   end
endmodule
